/* File: hdl/glue_consts.vh */
// Purpose: Named constants for the CPU bus glue peripheral
// Assumes: 100 MHz reference clock
// Notes: Register indices and refresh values are free choices
`ifndef GLUE_CONSTS_VH
`define GLUE_CONSTS_VH
// ----------------------------------------
// Register indices on the four address lines
// ----------------------------------------
`define REG_OUT_PORT 4'h0
`define REG_IN_PORT 4'h1
`define REG_WDOG_KEY_A 4'h2
`define REG_WDOG_KEY_B 4'h3
`define REG_WDOG_STAT 4'h4
// ----------------------------------------
// Watchdog, output port and read data defaults
// ----------------------------------------
`define WDOG_KEY_A_VAL 8'h55
`define WDOG_KEY_B_VAL 8'hAA
`define WDOG_TIMEOUT_MS 100
`define CLK_FREQ_KHZ 100000
`define WDOG_TIMEOUT_CYC (`WDOG_TIMEOUT_MS * `CLK_FREQ_KHZ)
`define OUT_PORT_RST 8'h00
`define BYTE_ZERO 8'h00
`endif

/* File: hdl/serial_router.v */
// Purpose: Four-way serial data crossbar under switch selects
// Assumes: Selects and data are already synchronised
// Notes: Each output registered to stay glitch free
`timescale 1ns/1ps
module serial_router (
  input wire ref_clk_i, // Clock
  input wire sys_rst_i, // Synchronous reset
  input wire [3:0] ser_in_i, // Serial data inputs
  input wire [7:0] ser_sel_i, // Two select bits per output
  output reg [3:0] ser_out_o // Serial data outputs
);
  integer k;
  // Each output follows exactly one input
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ser_out_o <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        ser_out_o[k] <= ser_in_i[ser_sel_i[2*k +: 2]];
      end
    end
  end
endmodule

/* File: hdl/bus_glue.v */
// Purpose: CPU bus glue with ports, watchdog, decode and serial routing
// Assumes: All CPU bus and pin inputs except sys_rst_i are asynchronous to ref_clk_i
// Notes: Registers are eight bits, picked by four address lines
`timescale 1ns/1ps
`include "glue_consts.vh"
module bus_glue #(
  parameter [3:0] ADDR_OUT = `REG_OUT_PORT, // Output port index
  parameter [3:0] ADDR_IN = `REG_IN_PORT, // Input port index
  parameter [3:0] ADDR_KEY_A = `REG_WDOG_KEY_A, // First refresh key index
  parameter [3:0] ADDR_KEY_B = `REG_WDOG_KEY_B, // Second refresh key index
  parameter [3:0] ADDR_STAT = `REG_WDOG_STAT, // Watchdog status index
  parameter [7:0] KEY_A = `WDOG_KEY_A_VAL, // First refresh value
  parameter [7:0] KEY_B = `WDOG_KEY_B_VAL, // Second refresh value
  parameter integer WDOG_CYCLES = `WDOG_TIMEOUT_CYC, // Timeout in clocks
  parameter integer PADDR_W = 8, // Peripheral decode address width
  parameter [8*PADDR_W-1:0] RANGE_BASE = 64'hF0E0_D0C0_B0A0_9080, // Range bases
  parameter [8*PADDR_W-1:0] RANGE_MASK = 64'hF0F0_F0F0_F0F0_F0F0 // Range masks
) (
  input wire ref_clk_i, // Clock, 100 MHz
  input wire sys_rst_i, // Synchronous reset
  input wire cs_n_i, // CPU chip-select, low active
  input wire rd_wr_i, // High read, low write
  input wire [PADDR_W-1:0] addr_i, // CPU address, low four pick register
  input wire [7:0] wdata_i, // CPU write data
  output reg [7:0] rdata_o, // CPU read data
  output reg rdata_oe_o, // High while driving data bus
  input wire [7:0] par_in_i, // Discrete inputs
  output reg [7:0] par_out_o, // Latched discrete outputs
  input wire wdog_dis_i, // Jumper, high disables watchdog
  output reg wdog_rst_o, // Watchdog system reset, high active
  output reg [7:0] periph_sel_n_o, // Peripheral selects, low active
  output reg [7:0] periph_rd_n_o, // Peripheral read strobes
  output reg [7:0] periph_wr_n_o, // Peripheral write strobes
  input wire [3:0] ser_in_i, // Serial data inputs
  input wire [7:0] ser_sel_i, // Serial select switches
  output wire [3:0] ser_out_o // Routed serial outputs
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [11+PADDR_W+8+8+1+4+8-1:0] meta_ff;
  reg [11+PADDR_W+8+8+1+4+8-1:0] sync_ff;
  wire [11+PADDR_W+8+8+1+4+8-1:0] raw_in;
  assign raw_in = {cs_n_i, rd_wr_i, addr_i, wdata_i, par_in_i, wdog_dis_i, ser_in_i, ser_sel_i, 9'h000};
  // Two flops on every external input except sys_rst_i
  always @(posedge ref_clk_i) begin
    meta_ff <= raw_in;
    sync_ff <= meta_ff;
  end
  wire cs_s = ~sync_ff[10+PADDR_W+8+8+1+4+8];
  wire rd_s = sync_ff[9+PADDR_W+8+8+1+4+8];
  wire [PADDR_W-1:0] addr_s = sync_ff[9+8+8+1+4+8 +: PADDR_W];
  wire [7:0] wdata_s = sync_ff[9+8+1+4+8 +: 8];
  wire [7:0] par_in_s = sync_ff[9+1+4+8 +: 8];
  wire dis_s = sync_ff[9+4+8];
  wire [3:0] ser_in_s = sync_ff[9+8 +: 4];
  wire [7:0] ser_sel_s = sync_ff[9 +: 8];
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  reg cs_d_ff;
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) cs_d_ff <= 1'b0;
    else cs_d_ff <= cs_s;
  end
  // One write strobe per write chip-select cycle, none for reads
  wire wr_stb = cs_s & ~cs_d_ff & ~rd_s;
  wire [3:0] reg_idx = addr_s[3:0];
  function hit;
    input [3:0] idx;
    input [3:0] want;
    begin
      hit = (idx == want);
    end
  endfunction
  // Output latch
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) par_out_o <= `OUT_PORT_RST;
    else if (wr_stb && hit(reg_idx, ADDR_OUT)) par_out_o <= wdata_s;
  end
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  reg key_a_ok_ff;
  reg [31:0] wd_cnt_ff;
  wire refresh = wr_stb && hit(reg_idx, ADDR_KEY_B) && key_a_ok_ff && (wdata_s == KEY_B);
  // First key arms, any write to key B disarms
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) key_a_ok_ff <= 1'b0;
    else if (wr_stb && hit(reg_idx, ADDR_KEY_A)) key_a_ok_ff <= (wdata_s == KEY_A);
    else if (wr_stb && hit(reg_idx, ADDR_KEY_B)) key_a_ok_ff <= 1'b0;
  end
  // Count up to timeout, then hold reset until refreshed or disabled
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || refresh || dis_s) begin
      wd_cnt_ff <= 32'h0000_0000;
      wdog_rst_o <= 1'b0;
    end else if (wd_cnt_ff >= WDOG_CYCLES - 1) begin
      wdog_rst_o <= 1'b1;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] nxt_rdata;
  // Read mux of the eight-bit registers
  always @* begin
    nxt_rdata = `BYTE_ZERO;
    if (hit(reg_idx, ADDR_OUT)) nxt_rdata = par_out_o;
    else if (hit(reg_idx, ADDR_IN)) nxt_rdata = par_in_s;
    else if (hit(reg_idx, ADDR_STAT)) nxt_rdata = {6'h00, dis_s, wdog_rst_o};
  end
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= `BYTE_ZERO;
      rdata_oe_o <= 1'b0;
    end else begin
      rdata_o <= nxt_rdata;
      rdata_oe_o <= cs_s & rd_s;
    end
  end
  // ----------------------------------------
  // Peripheral decode
  // ----------------------------------------
  integer p;
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      periph_sel_n_o <= 8'hFF;
      periph_rd_n_o <= 8'hFF;
      periph_wr_n_o <= 8'hFF;
    end else begin
      for (p = 0; p < 8; p = p + 1) begin
        periph_sel_n_o[p] <= ~(cs_s && ((addr_s & RANGE_MASK[p*PADDR_W +: PADDR_W]) ==
          RANGE_BASE[p*PADDR_W +: PADDR_W]));
        periph_rd_n_o[p] <= ~(cs_s && rd_s && ((addr_s & RANGE_MASK[p*PADDR_W +: PADDR_W]) ==
          RANGE_BASE[p*PADDR_W +: PADDR_W]));
        periph_wr_n_o[p] <= ~(cs_s && !rd_s && ((addr_s & RANGE_MASK[p*PADDR_W +: PADDR_W]) ==
          RANGE_BASE[p*PADDR_W +: PADDR_W]));
      end
    end
  end
  // ----------------------------------------
  // Serial routing
  // ----------------------------------------
  serial_router u_router (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ser_in_i(ser_in_s),
    .ser_sel_i(ser_sel_s),
    .ser_out_o(ser_out_o)
  );
endmodule

/* File: dv/cpu_model.sv */
// Purpose: CPU bus master model for bus_glue
// Assumes: One bus cycle per call, held n clocks
// Notes: Released address and data show inverted values
`timescale 1ns/1ps
module cpu_model (
  input wire ref_clk_i, // Clock
  output reg cs_n_o = 1'b1, // Chip-select, low active
  output reg rd_wr_o = 1'b1, // High read
  output reg [7:0] addr_o = 8'h00, // Address
  output reg [7:0] wdata_o = 8'h00 // Write data
);
  // One cycle, lines held past release for the sync lag
  task cyc(input rd, input [7:0] a, input [7:0] d, input integer n);
    begin
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      rd_wr_o <= rd;
      addr_o <= a;
      wdata_o <= d;
      repeat (n) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      addr_o <= ~a;
      wdata_o <= ~d;
      @(posedge ref_clk_i);
    end
  endtask
endmodule

/* File: dv/bus_glue_asserts.sv */
// Purpose: Port checks for bus_glue
// Assumes: Two-flop chip-select sync, registered outputs
// Notes: Bound to every bus_glue instance
`timescale 1ns/1ps
module bus_glue_asserts (
  input wire ref_clk_i, // Clock
  input wire sys_rst_i, // Reset
  input wire cs_n_i, // Chip-select
  input wire wdog_dis_i, // Jumper
  input wire [3:0] ser_in_i, // Serial in
  input wire [7:0] ser_sel_i, // Serial selects
  input wire [3:0] ser_out_o, // Serial out
  input wire [7:0] par_out_o, // Output latch
  input wire rdata_oe_o, // Bus drive
  input wire wdog_rst_o, // Watchdog reset
  input wire [7:0] periph_sel_n_o // Peripheral selects
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Expected crossbar output
  wire [3:0] route_exp = {ser_in_i[ser_sel_i[7:6]], ser_in_i[ser_sel_i[5:4]],
    ser_in_i[ser_sel_i[3:2]], ser_in_i[ser_sel_i[1:0]]};
  property p_idle_oe; cs_n_i [*5] |-> !rdata_oe_o; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("bus driven while idle");
  property p_oe_cause; rdata_oe_o |-> !($past(cs_n_i, 2) && $past(cs_n_i, 3) && $past(cs_n_i, 4)); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without select");
  property p_sel_idle; cs_n_i [*5] |-> &periph_sel_n_o; endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("peripheral selected while idle");
  property p_sel_one; $onehot0(~periph_sel_n_o); endproperty
  a_sel_one: assert property (p_sel_one) else $error("two peripherals selected");
  property p_route; ($stable(ser_in_i) && $stable(ser_sel_i)) [*4] |-> ser_out_o == route_exp; endproperty
  a_route: assert property (p_route) else $error("serial route wrong");
  property p_dis; wdog_dis_i [*4] |-> !wdog_rst_o; endproperty
  a_dis: assert property (p_dis) else $error("watchdog fired while disabled");
  // Jumper reaches wdog_rst_o through two flops and the output register
  property p_rise; $rose(wdog_rst_o) |-> !$past(wdog_dis_i, 3); endproperty
  a_rise: assert property (p_rise) else $error("watchdog rose while disabled");
  property p_latch; cs_n_i [*6] |-> $stable(par_out_o); endproperty
  a_latch: assert property (p_latch) else $error("output latch moved while idle");
  c_write: cover property ($changed(par_out_o));
  c_expire: cover property ($rose(wdog_rst_o));
  c_read: cover property ($rose(rdata_oe_o));
endmodule
bind bus_glue bus_glue_asserts i_chk (.*);

/* File: dv/bus_glue_tb_top.sv */
// Purpose: Self-checking bench for bus_glue
// Assumes: Watchdog shortened to 50 clocks
// Notes: Read results checked from a queue
`timescale 1ns/1ps
`include "glue_consts.vh"
module bus_glue_tb_top;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg wdog_dis_i = 1'b0;
  reg [7:0] par_in_i = 8'h00;
  reg [3:0] ser_in_i = 4'h0;
  reg [7:0] ser_sel_i = 8'h00;
  wire cs_n_i, rd_wr_i, rdata_oe_o, wdog_rst_o;
  wire [7:0] addr_i, wdata_i, rdata_o, par_out_o, periph_sel_n_o, periph_rd_n_o, periph_wr_n_o;
  wire [3:0] ser_out_o;
  reg [7:0] exp_q[$];
  reg [7:0] cur_a = 8'h00, hit = 8'h00, d;
  reg [1:0] oe_h = 2'b00;
  integer fails = 0, n_tests = 0, seed = 54, i;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  cpu_model i_cpu (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n_i), .rd_wr_o(rd_wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
  bus_glue #(.WDOG_CYCLES(50)) i_dut (.*);
  // Compare and count
  task chk(input [8*5:1] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Verdict and end of run
  task finish_test;
    begin
      if (fails == 0 && n_tests > 0 && exp_q.size() == 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Bus cycles
  task wr(input [7:0] a, input [7:0] v);
    i_cpu.cyc(1'b0, a, v, 5);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      i_cpu.cyc(1'b1, a, $random(seed), 6);
    end
  endtask
  // Bounded wait on the watchdog output
  task wait_rst(input v, input integer lim);
    begin
      repeat (lim) if (wdog_rst_o !== v) @(posedge ref_clk_i);
      chk("wdog", {7'h00, wdog_rst_o}, {7'h00, v});
      if (wdog_rst_o !== v) finish_test;
    end
  endtask
  // Output monitor: read data and peripheral selects
  always @(posedge ref_clk_i) if (sys_rst_i === 1'b0) begin
    oe_h <= {oe_h[0], rdata_oe_o};
    hit <= hit | ~periph_sel_n_o;
    if (rdata_oe_o === 1'b1 && oe_h === 2'b01) chk("rdata", rdata_o, exp_q.pop_front());
    if (periph_sel_n_o !== 8'hff) chk("psel", periph_sel_n_o, ~(8'h01 << (cur_a[7:4] - 4'h8)));
    if (periph_wr_n_o !== 8'hff) chk("pwr", periph_wr_n_o, ~(8'h01 << (cur_a[7:4] - 4'h8)));
    if (periph_rd_n_o !== 8'hff) chk("prd", periph_rd_n_o, 8'hff);
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk("pout", par_out_o, `OUT_PORT_RST);
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      par_in_i <= ~d;
      wr(`REG_OUT_PORT, d);
      chk("pout", par_out_o, d);
      rd(`REG_OUT_PORT, d);
      rd(`REG_IN_PORT, ~d);
    end
    rd(8'h05, 8'h00);
    wr(`REG_WDOG_KEY_A, `WDOG_KEY_A_VAL);
    wr(`REG_WDOG_KEY_B, `WDOG_KEY_B_VAL);
    chk("wdog", {7'h00, wdog_rst_o}, 8'h00);
    wr(`REG_WDOG_KEY_A, `WDOG_KEY_A_VAL);
    wr(`REG_WDOG_KEY_B, ~`WDOG_KEY_B_VAL);
    wait_rst(1'b1, 36);
    rd(`REG_WDOG_STAT, 8'h01);
    wdog_dis_i <= 1'b1;
    wait_rst(1'b0, 8);
    rd(`REG_WDOG_STAT, 8'h02);
    repeat (80) @(posedge ref_clk_i);
    chk("wdog", {7'h00, wdog_rst_o}, 8'h00);
    wdog_dis_i <= 1'b0;
    wait_rst(1'b1, 70);
    for (i = 0; i < 8; i = i + 1) begin
      cur_a <= {4'h8 + i[3:0], 4'hf};
      wr({4'h8 + i[3:0], 4'hf}, $random(seed));
    end
    chk("hit", hit, 8'hff);
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      ser_sel_i <= d;
      ser_in_i <= d[3:0] ^ i[3:0];
      repeat (5) @(posedge ref_clk_i);
      chk("ser", {4'h0, ser_out_o},
        {4'h0, ser_in_i[d[7:6]], ser_in_i[d[5:4]], ser_in_i[d[3:2]], ser_in_i[d[1:0]]});
    end
    finish_test;
  end
endmodule
